// File: src/ext_int_consts.vh
`ifndef EXT_INT_CONSTS_VH
`define EXT_INT_CONSTS_VH

`define ADDR_W            12
`define OFS_STATUS_CTRL   12'h000
`define OFS_BREAK_CTRL    12'h004
`define OFS_EVT_STATUS    12'h008
`define OFS_EVT_MASK      12'h00C
`define OFS_PIN_LEVEL     12'h010

`define BIT_MODE          0
`define BIT_REQ_MASK      1
`define BIT_ACK           2
`define BIT_PENDING       3
`define BIT_BRK_CLR_EN    0

`define EVT_W             3
`define EVT_LATCHED       0
`define EVT_VEC_ACK       1
`define EVT_SW_ACK        2

`define VECTOR_HI_ADDR    16'hFFFA
`define VECTOR_LO_ADDR    16'hFFFB

`define ZERO32            32'h00000000

`endif

// File: src/external_interrupt_latch.v
`timescale 1ns/1ns
`include "ext_int_consts.vh"
module external_interrupt_latch (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        irq_pin_n,
  input  wire        vector_fetch,
  input  wire        cpu_int_mask,
  input  wire        break_state,
  output wire        irq_to_cpu,
  output reg  [15:0] vector_hi_addr,
  output reg  [15:0] vector_lo_addr,
  output wire        branch_if_pin_high,
  output wire        branch_if_pin_low,
  output wire        irq
);

  reg                pin_meta_reg;
  reg                pin_sync_reg;
  reg                pin_prev_reg;
  reg                latch_reg;
  reg                latch_next;
  reg                mode_reg;
  reg                request_mask_reg;
  reg                break_clear_enable_reg;
  reg  [`EVT_W-1:0]  evt_status_reg;
  reg  [`EVT_W-1:0]  evt_status_next;
  reg  [`EVT_W-1:0]  evt_mask_reg;
  reg  [31:0]        rdata_next;

  wire               setup_ph;
  wire               access_ph;
  wire               wr_ok;
  wire               lane0;
  wire               falling_edge;
  wire               pin_low;
  wire               sw_ack_write;
  wire               sw_ack;
  wire               vec_ack;
  wire               pending_flag;
  wire [`EVT_W-1:0]  evt_set;
  wire [`EVT_W-1:0]  evt_clr;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OFS_STATUS_CTRL) || (a == `OFS_BREAK_CTRL) || (a == `OFS_EVT_STATUS) ||
               (a == `OFS_EVT_MASK) || (a == `OFS_PIN_LEVEL);
    end
  endfunction

  function wr_hit;
    input [11:0] a;
    input [11:0] ofs;
    input        ok;
    begin
      wr_hit = ok && (a == ofs);
    end
  endfunction

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~mapped(paddr);
  assign lane0     = pstrb[0];
  assign wr_ok     = access_ph & pwrite & lane0;

  // two-flop synchronizer; only pin_sync_reg and later are used
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= irq_pin_n;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign falling_edge = pin_prev_reg & ~pin_sync_reg;
  assign pin_low      = ~pin_sync_reg;

  assign branch_if_pin_high = pin_sync_reg;
  assign branch_if_pin_low  = pin_low;

  // software clear is gated off in break unless enabled
  assign sw_ack_write = wr_hit(paddr, `OFS_STATUS_CTRL, wr_ok) & pwdata[`BIT_ACK];
  assign sw_ack       = sw_ack_write & (~break_state | break_clear_enable_reg);
  assign vec_ack      = vector_fetch;

  always @* begin
    latch_next = latch_reg;
    if (sw_ack | vec_ack)
      latch_next = 1'b0;
    if (falling_edge)
      latch_next = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      latch_reg <= 1'b0;
    else
      latch_reg <= latch_next;
  end

  // level mode: low pin keeps request after the latch is acknowledged
  assign pending_flag = latch_reg | (mode_reg & pin_low);
  assign irq_to_cpu   = pending_flag & ~request_mask_reg & ~cpu_int_mask;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg               <= 1'b0;
      request_mask_reg       <= 1'b0;
      break_clear_enable_reg <= 1'b0;
      evt_mask_reg           <= {`EVT_W{1'b0}};
    end else begin
      if (wr_hit(paddr, `OFS_STATUS_CTRL, wr_ok)) begin
        mode_reg         <= pwdata[`BIT_MODE];
        request_mask_reg <= pwdata[`BIT_REQ_MASK];
      end
      if (wr_hit(paddr, `OFS_BREAK_CTRL, wr_ok))
        break_clear_enable_reg <= pwdata[`BIT_BRK_CLR_EN];
      if (wr_hit(paddr, `OFS_EVT_MASK, wr_ok))
        evt_mask_reg <= pwdata[`EVT_W-1:0];
    end
  end

  // vector addresses presented constantly, whether or not the request is forwarded
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_hi_addr <= `VECTOR_HI_ADDR;
      vector_lo_addr <= `VECTOR_LO_ADDR;
    end else begin
      vector_hi_addr <= `VECTOR_HI_ADDR;
      vector_lo_addr <= `VECTOR_LO_ADDR;
    end
  end

  assign evt_set[`EVT_LATCHED] = falling_edge & ~latch_reg;
  assign evt_set[`EVT_VEC_ACK] = vec_ack;
  assign evt_set[`EVT_SW_ACK]  = sw_ack;
  assign evt_clr = wr_hit(paddr, `OFS_EVT_STATUS, wr_ok) ? pwdata[`EVT_W-1:0] : {`EVT_W{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < `EVT_W; gi = gi + 1) begin : g_evt
      // set wins over write-one-to-clear
      always @* begin
        evt_status_next[gi] = evt_set[gi] | (evt_status_reg[gi] & ~evt_clr[gi]);
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      evt_status_reg <= {`EVT_W{1'b0}};
    else
      evt_status_reg <= evt_status_next;
  end

  assign irq = |(evt_status_reg & evt_mask_reg);

  always @* begin
    rdata_next = `ZERO32;
    case (paddr)
      `OFS_STATUS_CTRL: begin
        rdata_next[`BIT_PENDING]  = pending_flag;
        rdata_next[`BIT_ACK]      = 1'b0;
        rdata_next[`BIT_REQ_MASK] = request_mask_reg;
        rdata_next[`BIT_MODE]     = mode_reg;
      end
      `OFS_BREAK_CTRL: rdata_next[`BIT_BRK_CLR_EN] = break_clear_enable_reg;
      `OFS_EVT_STATUS: rdata_next[`EVT_W-1:0] = evt_status_reg;
      `OFS_EVT_MASK:   rdata_next[`EVT_W-1:0] = evt_mask_reg;
      `OFS_PIN_LEVEL:  rdata_next[0] = pin_sync_reg;
      default:         rdata_next = `ZERO32;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= `ZERO32;
    else if (setup_ph && !pwrite)
      prdata <= rdata_next;
  end

endmodule

// File: testbench/ext_int_checker.sv
`timescale 1ns/1ns
module ext_int_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic        irq_pin_n,
  input logic        vector_fetch,
  input logic        cpu_int_mask,
  input logic        break_state,
  input logic        irq_to_cpu,
  input logic        branch_if_pin_high,
  input logic        branch_if_pin_low,
  input logic [15:0] vector_hi_addr
);
  logic mode_q;
  logic msk;
  wire  wr0 = psel && penable && pwrite && paddr == 12'h000 && pstrb[0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'h0;
      msk    <= 1'h0;
    end else if (wr0) begin
      mode_q <= pwdata[0];
      msk    <= pwdata[1];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence fall_s;
    $fell(branch_if_pin_high) && !msk && !cpu_int_mask;
  endsequence
  sequence ack_s;
    (wr0 && pwdata[2] && !break_state || vector_fetch) && branch_if_pin_high;
  endsequence
  AST_VEC: assert property (vector_hi_addr == 16'hFFFA)
    else $error("vector address wrong");
  AST_SYNC: assert property ($past(presetn, 2) |-> branch_if_pin_high == $past(irq_pin_n, 2))
    else $error("pin sync latency wrong");
  AST_PINLOW: assert property (branch_if_pin_low != branch_if_pin_high)
    else $error("pin level outputs disagree");
  AST_EDGE: assert property (fall_s |=> irq_to_cpu || msk || cpu_int_mask)
    else $error("falling edge not latched");
  AST_ACK: assert property (ack_s |=> !irq_to_cpu)
    else $error("acknowledge did not clear");
  AST_LEVEL: assert property (mode_q && !branch_if_pin_high && !msk && !cpu_int_mask |-> irq_to_cpu)
    else $error("low level not pending");
  AST_MASK: assert property (msk || cpu_int_mask |-> !irq_to_cpu)
    else $error("masked request forwarded");
  AST_RST: assert property ($rose(presetn) |-> !irq_to_cpu)
    else $error("request pending after reset");
endmodule
bind external_interrupt_latch ext_int_checker chk (.*);

// File: testbench/pin_driver.sv
`timescale 1ns/1ns
module pin_driver (
  input  logic pclk,
  input  logic drive_low,
  output logic irq_pin_n
);
  initial irq_pin_n = 1'h1;
  always @(posedge pclk) irq_pin_n <= !drive_low;
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, low = 1'h0;
  logic        vector_fetch = 1'h0, cpu_int_mask = 1'h0, break_state = 1'h0;
  logic        pready, pslverr, irq_pin_n, irq_to_cpu, branch_if_pin_high, branch_if_pin_low, irq;
  logic [3:0]  pstrb = 4'hF;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v, e;
  logic [15:0] vector_hi_addr, vector_lo_addr;
  int          n_fail = 0, n_tests = 0, cyc = 0;
  external_interrupt_latch dut (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .irq_pin_n          (irq_pin_n),
    .vector_fetch       (vector_fetch),
    .cpu_int_mask       (cpu_int_mask),
    .break_state        (break_state),
    .irq_to_cpu         (irq_to_cpu),
    .vector_hi_addr     (vector_hi_addr),
    .vector_lo_addr     (vector_lo_addr),
    .branch_if_pin_high (branch_if_pin_high),
    .branch_if_pin_low  (branch_if_pin_low),
    .irq                (irq)
  );
  pin_driver far (.pclk(pclk), .drive_low(low), .irq_pin_n(irq_pin_n));
  initial forever #5 pclk = ~pclk;
  task print_verdict;
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      n_fail++;
      print_verdict;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    v = prdata;
    e = {31'h0, pslverr};
    psel    <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  task pulse;
    @(posedge pclk) low <= 1'h1;
    tick(3);
    @(posedge pclk) low <= 1'h0;
    tick(3);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    xfer(0, 12'h000, 0); chk(v, 32'h0);
    xfer(0, 12'h004, 0); chk(v, 32'h0);
    xfer(0, 12'h010, 0); chk(v, 32'h1);
    chk(e, 32'h0);
    chk(vector_hi_addr, 32'hFFFA);
    chk(vector_lo_addr, 32'hFFFB);
    xfer(1, 12'h00C, 32'h7);
    @(posedge pclk) low <= 1'h1;
    tick(4);
    chk(irq_to_cpu, 1);
    chk(branch_if_pin_low, 1);
    chk(irq, 1);
    xfer(0, 12'h000, 0); chk(v, 32'h8);
    xfer(1, 12'h000, 32'h2); chk(irq_to_cpu, 0);
    xfer(0, 12'h000, 0); chk(v, 32'hA);
    xfer(1, 12'h000, 32'h6);
    xfer(0, 12'h000, 0); chk(v, 32'h2);
    xfer(1, 12'h008, 32'h7); chk(irq, 0);
    xfer(0, 12'h020, 0); chk(v, 32'h0);
    chk(e, 32'h1);
    xfer(1, 12'h000, 32'h0);
    @(posedge pclk) low <= 1'h0;
    tick(3);
    pulse; chk(irq_to_cpu, 1);
    @(posedge pclk) cpu_int_mask <= 1'h1;
    tick(1); chk(irq_to_cpu, 0);
    @(posedge pclk) vector_fetch <= 1'h1;
    @(posedge pclk) vector_fetch <= 1'h0;
    cpu_int_mask <= 1'h0;
    tick(1); chk(irq_to_cpu, 0);
    xfer(0, 12'h008, 0); chk(v, 32'h3);
    xfer(1, 12'h000, 32'h1);
    @(posedge pclk) low <= 1'h1;
    tick(3); chk(irq_to_cpu, 1);
    xfer(1, 12'h000, 32'h5); chk(irq_to_cpu, 1);
    @(posedge pclk) low <= 1'h0;
    tick(3); chk(irq_to_cpu, 0);
    xfer(1, 12'h000, 32'h0);
    pulse;
    @(posedge pclk) break_state <= 1'h1;
    xfer(1, 12'h000, 32'h4); chk(irq_to_cpu, 1);
    xfer(1, 12'h004, 32'h1);
    xfer(1, 12'h000, 32'h4);
    @(posedge pclk) break_state <= 1'h0;
    tick(2); chk(irq_to_cpu, 0);
    xfer(1, 12'h000, 32'h1);
    @(posedge pclk) low <= 1'h1;
    tick(3);
    @(posedge pclk) presetn <= 1'h0;
    tick(1); chk(irq_to_cpu, 0);
    print_verdict;
  end
endmodule
